// file: hw/adcsq_consts.vh
// register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef ADCSQ_CONSTS_VH
`define ADCSQ_CONSTS_VH
`define ADCSQ_OFF_INTCTL      8'h0b
`define ADCSQ_OFF_PIRF        8'h0c
`define ADCSQ_OFF_RESH        8'h1e
`define ADCSQ_OFF_CTL0        8'h1f
`define ADCSQ_OFF_PIEN        8'h8c
`define ADCSQ_OFF_REFC        8'h9b
`define ADCSQ_OFF_ANALOG_PIN_SELECT       8'h9d
`define ADCSQ_OFF_RESL        8'h9e
`define ADCSQ_OFF_CTL1        8'h9f
`define ADCSQ_RST_INTCTL      8'h00
`define ADCSQ_RST_PIRF        8'h00
`define ADCSQ_RST_CTL0        8'h00
`define ADCSQ_RST_PIEN        8'h00
`define ADCSQ_RST_REFC        8'h00
`define ADCSQ_RST_ANALOG_PIN_SELECT       8'hff
`define ADCSQ_RST_CTL1        8'h00
`define ADCSQ_RST_RES         8'h00
`define ADCSQ_MASK_PIRF       8'h4f
`define ADCSQ_MASK_PIEN       8'h4f
`define ADCSQ_MASK_REFC       8'hf0
`define ADCSQ_MASK_CTL1       8'hf0
`define ADCSQ_MASK_ANALOG_PIN_SELECT      8'h3f
`define ADCSQ_BIT_ON          0
`define ADCSQ_BIT_GO          2
`define ADCSQ_BIT_CS_LO       6
`define ADCSQ_BIT_DONE        6
`define ADCSQ_BIT_GIE         7
`define ADCSQ_BIT_PERIPHERAL_IRQ_ENABLE        6
`define ADCSQ_BIT_REF_H       7
`define ADCSQ_BIT_REF_L       6
`define ADCSQ_BIT_FMT         7
`define ADCSQ_CS_RC           2'h3
`define ADCSQ_TRIG_MODE       4'hb
`define ADCSQ_SETTLE_TAD      4'h1
`define ADCSQ_CONV_BITS       4'hc
`define ADCSQ_DONE_TAD        4'hd
`define ADCSQ_RECOVER_TAD     2'h2
`define ADCSQ_DIV_2           10'h002
`define ADCSQ_DIV_8           10'h008
`define ADCSQ_DIV_32          10'h020
`define ADCSQ_REF_SCALE       3
`define ADCSQ_INSTR_CLKS      3'h4
`endif

// file: hw/adcsq_sync.v
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module adcsq_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// file: hw/adcsq_tick.v
// conversion clock tick generator: divided oscillator or sampled rc clock edge
`timescale 1ns/1ns
`include "adcsq_consts.vh"
module adcsq_tick (
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       run_in,
  input  wire [1:0] clock_sel_in,
  input  wire       int_ref_in,
  input  wire       rc_clk_in,
  output reg        tick_out
);
  reg  [9:0] cnt_ff;
  reg        rc_prev_ff;
  reg  [9:0] div;
  wire       rc_s;

  adcsq_sync #(.WIDTH(1)) u_rc_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (rc_clk_in),
    .sync_out (rc_s)
  );

  // internal reference stretches each divided period eightfold
  always @* begin
    case (clock_sel_in)
      2'h0:    div = `ADCSQ_DIV_2;
      2'h1:    div = `ADCSQ_DIV_8;
      default: div = `ADCSQ_DIV_32;
    endcase
    if (int_ref_in) begin
      div = div << `ADCSQ_REF_SCALE;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_ff     <= 10'h000;
      rc_prev_ff <= 1'b0;
      tick_out   <= 1'b0;
    end else begin
      rc_prev_ff <= rc_s;
      tick_out   <= 1'b0;
      if (!run_in) begin
        cnt_ff <= 10'h000;
      end else if (clock_sel_in == `ADCSQ_CS_RC) begin
        tick_out <= rc_s & ~rc_prev_ff;
      end else if (cnt_ff >= div - 10'h001) begin
        cnt_ff   <= 10'h000;
        tick_out <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 10'h001;
      end
    end
  end
endmodule

// file: hw/adcsq_top.v
// converter sequencer: registers, trigger, timing, sleep and result handling
// Operation
// - after completion the capacitor stays disconnected for two conversion periods
// - trigger in mode 1011b with converter on sets go and clears timer1
// - with converter off the trigger is ignored but timer1 still clears
// - reset restores registers, turns converter off, abandons conversion
// - result bytes survive non power-on resets, undefined after power-on
// - clearing go early leaves unresolved result bits at zero; in the rc start delay or first settle clock it loads the prior sar_ff
// - acquisition interval is independent of kept resolution
// - with rc clock, start waits one instruction cycle after go
// - sleep completion clears go, loads results, wakes if enabled
// - sleep completion without enable keeps sleep and converter-on set
// - non rc clock: sleep aborts and powers down, converter-on stays set
// - conversion is one settling period plus twelve bit periods
// - done flag rises at period fourteen start, go clears at its end
// - clock select gives 2, 8, 32 oscillator periods or rc, x8 on internal ref
// - setting converter-on and go in one write clears go
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "adcsq_consts.vh"
module adcsq_top #(
  parameter RES_BITS = 12
) (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        por_in,
  input  wire [7:0]  addr_in,
  input  wire [7:0]  wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [7:0]  rdata_out,
  input  wire [3:0]  compare_unit_mode_field_in,
  input  wire        special_trigger_in,
  input  wire        sleep_in,
  input  wire        rc_clk_in,
  input  wire        comparator_in,
  output reg         timer1_reset_out,
  output reg         sample_connect_out,
  output reg         analog_power_out,
  output reg  [3:0]  input_channel_select_out,
  output reg  [11:0] dac_code_out,
  output reg         irq_out,
  output reg         wake_out
);
  localparam ST_IDLE    = 3'h0;
  localparam ST_DELAY   = 3'h1;
  localparam ST_SETTLE  = 3'h2;
  localparam ST_CONVERT = 3'h3;
  localparam ST_DONE    = 3'h4;
  localparam ST_RECOVER = 3'h5;

  reg [7:0]  ctl0_ff;
  reg [7:0]  ctl1_ff;
  reg [7:0]  refc_ff;
  reg [7:0]  analog_pin_select_ff;
  reg [7:0]  intctl_ff;
  reg [7:0]  pirf_ff;
  reg [7:0]  pien_ff;
  reg [7:0]  resh_ff;
  reg [7:0]  resl_ff;
  reg [2:0]  state_ff;
  reg [3:0]  tad_cnt_ff;
  reg [2:0]  delay_ff;
  reg [11:0] sar_ff;
  reg [11:0] trial_ff;
  reg        trig_prev_ff;
  reg        sleep_done_ff;

  reg [2:0]  nxt_state;
  reg [7:0]  nxt_ctl0;
  reg        nxt_done;
  reg        load_res;

  wire [1:0]  cs        = ctl0_ff[7:`ADCSQ_BIT_CS_LO];
  wire        conv_on   = ctl0_ff[`ADCSQ_BIT_ON];
  wire        go        = ctl0_ff[`ADCSQ_BIT_GO];
  wire        int_ref   = refc_ff[`ADCSQ_BIT_REF_H] | refc_ff[`ADCSQ_BIT_REF_L];
  wire        is_rc     = (cs == `ADCSQ_CS_RC);
  wire        run       = (state_ff != ST_IDLE) && (state_ff != ST_DELAY);
  wire        tick;
  wire [3:0]  mode_s;
  wire        trig_s;
  wire        sleep_s;
  wire        cmp_s;
  wire        trig_edge = trig_s & ~trig_prev_ff;
  // without rc clock the analog part is unpowered while asleep
  wire        powered   = conv_on && (is_rc || !sleep_s);
  // the last period of a finished conversion hands over to recovery,
  // so the cleared go flag must not send the sequencer straight to idle
  wire        finishing = (state_ff == ST_DONE) && tick;
  // limitation: the comparator loop (trial register, dac, two-flop sync)
  // spans three clocks, so results are only exact when a conversion
  // period lasts at least four clocks; two oscillator periods is too short

  adcsq_sync #(.WIDTH(7)) u_in_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({compare_unit_mode_field_in, special_trigger_in, sleep_in, comparator_in}),
    .sync_out ({mode_s, trig_s, sleep_s, cmp_s})
  );

  adcsq_tick u_tick (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .run_in       (run),
    .clock_sel_in (cs),
    .int_ref_in   (int_ref),
    .rc_clk_in    (rc_clk_in),
    .tick_out     (tick)
  );

  // justify the successive-approximation value into the two result bytes
  function [15:0] adcsq_place;
    input [11:0] val;
    input        right;
    begin
      if (right) begin
        adcsq_place = {4'h0, val};
      end else begin
        adcsq_place = {val, 4'h0};
      end
    end
  endfunction

  function adcsq_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      adcsq_hit = (a == off);
    end
  endfunction

  wire [15:0] placed = adcsq_place(sar_ff, ctl1_ff[`ADCSQ_BIT_FMT]);

  // control register next value, with hardware effects on go
  always @* begin
    nxt_ctl0 = ctl0_ff;
    nxt_done = 1'b0;
    load_res = 1'b0;
    if (wr_in && adcsq_hit(addr_in, `ADCSQ_OFF_CTL0)) begin
      nxt_ctl0 = wdata_in;
      if (wdata_in[`ADCSQ_BIT_ON] && !conv_on) begin
        nxt_ctl0[`ADCSQ_BIT_GO] = 1'b0;
      end
    end
    if (trig_edge && (mode_s == `ADCSQ_TRIG_MODE) && conv_on) begin
      nxt_ctl0[`ADCSQ_BIT_GO] = 1'b1;
    end
    if (state_ff == ST_DONE && tick) begin
      nxt_ctl0[`ADCSQ_BIT_GO] = 1'b0;
      load_res = 1'b1;
    end
    if (state_ff == ST_CONVERT && tick && tad_cnt_ff == `ADCSQ_CONV_BITS - 4'h1) begin
      nxt_done = 1'b1;
    end
    if ((run || state_ff == ST_DELAY) && !nxt_ctl0[`ADCSQ_BIT_GO]
        && state_ff != ST_RECOVER && !load_res) begin
      load_res = 1'b1;
    end
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (go && powered) begin
          nxt_state = is_rc ? ST_DELAY : ST_SETTLE;
        end
      end
      ST_DELAY: begin
        if (delay_ff == `ADCSQ_INSTR_CLKS - 3'h1) begin
          nxt_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (tick) begin
          nxt_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (tick && tad_cnt_ff == `ADCSQ_CONV_BITS - 4'h1) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (tick) begin
          nxt_state = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (tick && tad_cnt_ff == {2'h0, `ADCSQ_RECOVER_TAD} - 4'h1) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (!powered || (!nxt_ctl0[`ADCSQ_BIT_GO] && state_ff != ST_RECOVER
        && !finishing)) begin
      nxt_state = ST_IDLE;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctl0_ff       <= `ADCSQ_RST_CTL0;
      ctl1_ff       <= `ADCSQ_RST_CTL1;
      refc_ff       <= `ADCSQ_RST_REFC;
      analog_pin_select_ff      <= `ADCSQ_RST_ANALOG_PIN_SELECT;
      intctl_ff     <= `ADCSQ_RST_INTCTL;
      pirf_ff       <= `ADCSQ_RST_PIRF;
      pien_ff       <= `ADCSQ_RST_PIEN;
      state_ff      <= ST_IDLE;
      tad_cnt_ff    <= 4'h0;
      delay_ff      <= 3'h0;
      sar_ff        <= 12'h000;
      trial_ff      <= 12'h800;
      trig_prev_ff  <= 1'b0;
      sleep_done_ff <= 1'b0;
    end else begin
      ctl0_ff      <= nxt_ctl0;
      state_ff     <= nxt_state;
      trig_prev_ff <= trig_s;
      if (wr_in && adcsq_hit(addr_in, `ADCSQ_OFF_CTL1)) begin
        ctl1_ff <= wdata_in & `ADCSQ_MASK_CTL1;
      end
      if (wr_in && adcsq_hit(addr_in, `ADCSQ_OFF_REFC)) begin
        refc_ff <= wdata_in & `ADCSQ_MASK_REFC;
      end
      if (wr_in && adcsq_hit(addr_in, `ADCSQ_OFF_ANALOG_PIN_SELECT)) begin
        analog_pin_select_ff <= wdata_in & `ADCSQ_MASK_ANALOG_PIN_SELECT;
      end
      if (wr_in && adcsq_hit(addr_in, `ADCSQ_OFF_INTCTL)) begin
        intctl_ff <= wdata_in;
      end
      if (wr_in && adcsq_hit(addr_in, `ADCSQ_OFF_PIEN)) begin
        pien_ff <= wdata_in & `ADCSQ_MASK_PIEN;
      end
      // hardware set wins over a software clear in the same cycle
      if (wr_in && adcsq_hit(addr_in, `ADCSQ_OFF_PIRF)) begin
        pirf_ff <= (wdata_in & `ADCSQ_MASK_PIRF) | {1'b0, nxt_done, 6'h00};
      end else if (nxt_done) begin
        pirf_ff[`ADCSQ_BIT_DONE] <= 1'b1;
      end
      // remembers a completion in sleep until the device leaves it
      if (!sleep_s) begin
        sleep_done_ff <= 1'b0;
      end else if (nxt_done) begin
        sleep_done_ff <= 1'b1;
      end
      if (state_ff == ST_DELAY) begin
        delay_ff <= delay_ff + 3'h1;
      end else begin
        delay_ff <= 3'h0;
      end
      if (nxt_state != state_ff) begin
        tad_cnt_ff <= 4'h0;
      end else if (tick) begin
        tad_cnt_ff <= tad_cnt_ff + 4'h1;
      end
      if (state_ff == ST_SETTLE) begin
        sar_ff   <= 12'h000;
        trial_ff <= 12'h800 >> (12 - RES_BITS);
      end else if (state_ff == ST_CONVERT && tick) begin
        if (cmp_s) begin
          sar_ff <= sar_ff | trial_ff; // unresolved bits stay zero
        end
        trial_ff <= trial_ff >> 1;
      end
    end
  end

  // result bytes are not reset except at power-on, where any value is allowed
  always @(posedge clk_in) begin
    if (!rst_n_in && por_in) begin
      resh_ff <= `ADCSQ_RST_RES;
      resl_ff <= `ADCSQ_RST_RES;
    end else if (rst_n_in && load_res) begin
      resh_ff <= placed[15:8];
      resl_ff <= placed[7:0];
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out                <= 8'h00;
      timer1_reset_out         <= 1'b0;
      sample_connect_out       <= 1'b0;
      analog_power_out         <= 1'b0;
      input_channel_select_out <= 4'h0;
      dac_code_out             <= 12'h000;
      irq_out                  <= 1'b0;
      wake_out                 <= 1'b0;
    end else begin
      rdata_out <= 8'h00;
      if (rd_in) begin
        case (addr_in)
          `ADCSQ_OFF_INTCTL: rdata_out <= intctl_ff;
          `ADCSQ_OFF_PIRF:   rdata_out <= pirf_ff;
          `ADCSQ_OFF_RESH:   rdata_out <= resh_ff;
          `ADCSQ_OFF_CTL0:   rdata_out <= ctl0_ff;
          `ADCSQ_OFF_PIEN:   rdata_out <= pien_ff;
          `ADCSQ_OFF_REFC:   rdata_out <= refc_ff;
          `ADCSQ_OFF_ANALOG_PIN_SELECT:  rdata_out <= analog_pin_select_ff;
          `ADCSQ_OFF_RESL:   rdata_out <= resl_ff;
          `ADCSQ_OFF_CTL1:   rdata_out <= ctl1_ff;
          default:           rdata_out <= 8'h00;
        endcase
      end
      timer1_reset_out <= trig_edge && (mode_s == `ADCSQ_TRIG_MODE);
      // capacitor tracks only while idle or in the rc start delay, and powered
      sample_connect_out <= powered && (nxt_state == ST_IDLE || nxt_state == ST_DELAY)
                            && state_ff != ST_RECOVER;
      analog_power_out   <= powered;
      input_channel_select_out <= {ctl0_ff[1], ctl0_ff[5:3]};
      dac_code_out       <= sar_ff | trial_ff;
      irq_out <= pirf_ff[`ADCSQ_BIT_DONE] & pien_ff[`ADCSQ_BIT_DONE]
                 & intctl_ff[`ADCSQ_BIT_PERIPHERAL_IRQ_ENABLE] & intctl_ff[`ADCSQ_BIT_GIE];
      wake_out <= sleep_s & pirf_ff[`ADCSQ_BIT_DONE] & pien_ff[`ADCSQ_BIT_DONE]
                  & ~sleep_done_ff | (sleep_done_ff & pien_ff[`ADCSQ_BIT_DONE]);
    end
  end
endmodule

// file: tb/adcsq_analog_model.sv
// behavioural analog side: comparator on the trial code and the rc oscillator
`timescale 1ns/1ns
module adcsq_analog_model #(
  parameter logic [11:0] LEVEL      = 12'h800,
  parameter int          RC_HALF_NS = 125
) (
  input  wire logic [11:0] dac_code_in,
  output logic             comparator_out,
  output logic             rc_clk_out
);
  // dedicated oscillator runs free, so its edges are never framed
  initial rc_clk_out = 1'b0;
  always #(RC_HALF_NS) rc_clk_out = ~rc_clk_out;
  // trial bit kept while the input is at or above the trial code
  assign comparator_out = (dac_code_in <= LEVEL);
endmodule

// file: tb/adcsq_top_asserts.sv
// concurrent checks on the converter sequencer ports
`timescale 1ns/1ns
`include "adcsq_consts.vh"
module adcsq_top_asserts #(
  parameter RES_BITS = 12
) (
  input wire       clk_in,
  input wire       rst_n_in,
  input wire       wr_in,
  input wire [3:0] compare_unit_mode_field_in,
  input wire       special_trigger_in,
  input wire       sleep_in,
  input wire       timer1_reset_out,
  input wire       sample_connect_out,
  input wire       analog_power_out,
  input wire [3:0] input_channel_select_out,
  input wire       irq_out,
  input wire       wake_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_trig_clears_timer: assert property (
    $rose(special_trigger_in) && compare_unit_mode_field_in == `ADCSQ_TRIG_MODE
    |-> ##[1:6] timer1_reset_out)
    else $error("timer clear missing after trigger");
  a_timer_needs_mode: assert property (
    timer1_reset_out |-> compare_unit_mode_field_in == `ADCSQ_TRIG_MODE)
    else $error("timer clear outside trigger mode");
  a_timer_one_cycle: assert property (
    timer1_reset_out |=> !timer1_reset_out)
    else $error("timer clear longer than one cycle");
  a_recovery_gap: assert property (
    $fell(sample_connect_out) |=> !sample_connect_out [*3])
    else $error("capacitor reconnected too early");
  a_sample_powered: assert property (
    sample_connect_out |-> analog_power_out)
    else $error("sampling while powered down");
  a_wake_in_sleep: assert property (
    $rose(wake_out) |-> sleep_in && !sample_connect_out)
    else $error("wake request outside sleep completion");
  a_irq_cause: assert property (
    $rose(irq_out) |-> !sample_connect_out || $past(wr_in) || $past(wr_in, 2))
    else $error("interrupt without completion or write");
  a_chan_by_write: assert property (
    $changed(input_channel_select_out) |-> $past(wr_in) || $past(wr_in, 2))
    else $error("channel changed without a write");

  c_timer: cover property ($rose(timer1_reset_out));
  c_wake: cover property ($rose(wake_out));
  c_irq: cover property ($rose(irq_out));
endmodule

// file: tb/adcsq_top_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
`include "adcsq_consts.vh"
module adcsq_top_tb;
  localparam logic [11:0] LEVEL = 12'ha5c;
  localparam logic [7:0]  CTL0  = `ADCSQ_OFF_CTL0;
  localparam logic [7:0]  PIR   = `ADCSQ_OFF_PIRF;
  localparam logic [7:0]  RESH  = `ADCSQ_OFF_RESH;
  localparam logic [7:0]  RESL  = `ADCSQ_OFF_RESL;
  logic       clk_in                     = 1'b0;
  logic       rst_n_in                   = 1'b0;
  logic       por_in                     = 1'b1;
  logic [7:0] addr_in                    = 8'h00;
  logic [7:0] wdata_in                   = 8'h00;
  logic       wr_in                      = 1'b0;
  logic       rd_in                      = 1'b0;
  logic [3:0] compare_unit_mode_field_in = 4'h0;
  logic       special_trigger_in         = 1'b0;
  logic       sleep_in                   = 1'b0;
  wire        rc_clk_in;
  wire        comparator_in;
  wire [7:0]  rdata_out;
  wire        timer1_reset_out;
  wire        sample_connect_out;
  wire        analog_power_out;
  wire [3:0]  input_channel_select_out;
  wire [11:0] dac_code_out;
  wire        irq_out;
  wire        wake_out;
  int         n_fail   = 0;
  int         compares = 0;
  int         cyc      = 0;
  int         t1_cnt   = 0;

  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (timer1_reset_out === 1'b1) t1_cnt <= t1_cnt + 1;
  end

  adcsq_top #(.RES_BITS(12)) i_adcsq_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .por_in(por_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .compare_unit_mode_field_in(compare_unit_mode_field_in),
    .special_trigger_in(special_trigger_in), .sleep_in(sleep_in), .rc_clk_in(rc_clk_in),
    .comparator_in(comparator_in), .timer1_reset_out(timer1_reset_out),
    .sample_connect_out(sample_connect_out), .analog_power_out(analog_power_out),
    .input_channel_select_out(input_channel_select_out), .dac_code_out(dac_code_out),
    .irq_out(irq_out), .wake_out(wake_out));

  // rc period of 250 ns gives five system clocks per conversion period
  adcsq_analog_model #(.LEVEL(LEVEL)) i_adcsq_analog_model (
    .dac_code_in(dac_code_out), .comparator_out(comparator_in), .rc_clk_out(rc_clk_in));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic wait_idle;
    logic [7:0] d;
    d = 8'h04;
    for (int i = 0; i < 2000 && d[2] === 1'b1; i++) rd(CTL0, d);
  endtask

  task automatic convert(input logic [7:0] ctl, input logic slp, output int took);
    int t0;
    wr(CTL0, ctl);
    repeat (200) @(posedge clk_in);
    wr(CTL0, ctl | 8'h04);
    t0 = cyc;
    sleep_in <= slp;
    wait_idle();
    took = cyc - t0;
  endtask

  task automatic pulse;
    repeat (10) @(posedge clk_in);
    special_trigger_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    special_trigger_in <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask

  task automatic t_regs;
    logic [7:0] r;
    rd_chk(CTL0, 8'h00);
    rd_chk(PIR, 8'h00);
    rd_chk(`ADCSQ_OFF_REFC, 8'h00);
    rd_chk(`ADCSQ_OFF_CTL1, 8'h00);
    rd_chk(`ADCSQ_OFF_ANALOG_PIN_SELECT, 8'hff);
    wr(8'h20, 8'h5a);
    rd_chk(8'h20, 8'h00);
    rd(RESH, r);
    wr(RESH, ~r);
    rd_chk(RESH, r);
  endtask

  task automatic t_full;
    int took;
    int conv_clock_period;
    wr(`ADCSQ_OFF_PIEN, 8'h40);
    wr(`ADCSQ_OFF_INTCTL, 8'hc0);
    wr(`ADCSQ_OFF_CTL1, 8'h80);
    for (int i = 0; i < 3; i++) begin
      conv_clock_period = (i == 0) ? 32 : (i == 1) ? 8 : 16;
      wr(`ADCSQ_OFF_REFC, (i == 2) ? 8'h80 : 8'h00);
      wr(PIR, 8'h00);
      convert((i == 0) ? 8'h81 : (i == 1) ? 8'h41 : 8'h01, 1'b0, took);
      chk(took >= 14 * conv_clock_period && took <= 15 * conv_clock_period + 12, 1'b1);
      chk(irq_out, 1'b1);
      rd_chk(PIR, 8'h40);
      rd_chk(RESH, {4'h0, LEVEL[11:8]});
      rd_chk(RESL, LEVEL[7:0]);
      wr(PIR, 8'h00);
      repeat (40) @(posedge clk_in);
      chk(irq_out, 1'b0);
    end
    wr(`ADCSQ_OFF_REFC, 8'h00);
  endtask

  task automatic t_trig;
    int n;
    wr(CTL0, 8'h00);
    wr(CTL0, 8'h05);
    rd_chk(CTL0, 8'h01);
    compare_unit_mode_field_in <= `ADCSQ_TRIG_MODE;
    wr(CTL0, 8'h19);
    repeat (200) @(posedge clk_in);
    chk(input_channel_select_out, 4'h3);
    for (int on = 1; on >= 0; on--) begin
      n = t1_cnt;
      pulse();
      chk(t1_cnt, n + 1);
      rd_chk(CTL0, (on == 1) ? 8'h1d : 8'h18);
      wait_idle();
      repeat (40) @(posedge clk_in);
      wr(CTL0, 8'h18);
    end
    compare_unit_mode_field_in <= 4'h0;
    n = t1_cnt;
    pulse();
    chk(t1_cnt, n);
  endtask

  task automatic t_abort;
    logic [7:0] d;
    wr(PIR, 8'h00);
    wr(CTL0, 8'h41);
    repeat (200) @(posedge clk_in);
    wr(CTL0, 8'h45);
    repeat (40) @(posedge clk_in);
    wr(CTL0, 8'h41);
    repeat (40) @(posedge clk_in);
    rd_chk(RESL, 8'h00);
    rd(RESH, d);
    chk(d & ~{4'h0, LEVEL[11:8]}, 8'h00);
    rd_chk(PIR, 8'h00);
  endtask

  task automatic t_sleep;
    int took;
    for (int en = 0; en < 2; en++) begin
      wr(PIR, 8'h00);
      wr(`ADCSQ_OFF_PIEN, (en == 1) ? 8'h40 : 8'h00);
      convert(8'hc1, 1'b1, took);
      chk(took >= 69, 1'b1);
      chk(wake_out, en[0]);
      rd_chk(CTL0, 8'hc1);
      rd_chk(RESL, LEVEL[7:0]);
      sleep_in <= 1'b0;
      repeat (40) @(posedge clk_in);
    end
  endtask

  task automatic t_sleep_abort;
    logic [7:0] d;
    wr(CTL0, 8'h01);
    repeat (200) @(posedge clk_in);
    wr(CTL0, 8'h05);
    repeat (6) @(posedge clk_in);
    sleep_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk(analog_power_out, 1'b0);
    rd(CTL0, d);
    chk(d[0], 1'b1);
    sleep_in <= 1'b0;
    wr(CTL0, 8'h01);
    repeat (40) @(posedge clk_in);
  endtask

  task automatic t_reset;
    logic [7:0] h;
    logic [7:0] l;
    rd(RESH, h);
    rd(RESL, l);
    wr(CTL0, 8'h05);
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_chk(CTL0, 8'h00);
    chk(analog_power_out, 1'b0);
    repeat (60) @(posedge clk_in);
    rd_chk(RESH, h);
    rd_chk(RESL, l);
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_in   <= 1'b0;
    t_regs();
    t_full();
    t_trig();
    t_abort();
    t_sleep();
    t_sleep_abort();
    t_reset();
    end_of_test();
  end

  // a full pass needs a few thousand cycles
  initial begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    end_of_test();
  end
endmodule

bind adcsq_top adcsq_top_asserts #(.RES_BITS(RES_BITS)) i_adcsq_top_asserts (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .wr_in(wr_in),
  .compare_unit_mode_field_in(compare_unit_mode_field_in),
  .special_trigger_in(special_trigger_in), .sleep_in(sleep_in),
  .timer1_reset_out(timer1_reset_out), .sample_connect_out(sample_connect_out),
  .analog_power_out(analog_power_out), .input_channel_select_out(input_channel_select_out),
  .irq_out(irq_out), .wake_out(wake_out));
